// file: atrcs_defines.svh
// Register offsets, field positions, reset values and codes for the retry and swap slice
`ifndef ATRCS_DEFINES_SVH
`define ATRCS_DEFINES_SVH
`define ATRCS_OFF_RETRY 8'h08
`define ATRCS_OFF_SWAP 8'h0c
`define ATRCS_OFF_CMP 8'h10
`define ATRCS_OFF_CTRL 8'h14
`define ATRCS_OFF_IRQ_STAT 8'h18
`define ATRCS_OFF_IRQ_MASK 8'h1c
`define ATRCS_OFF_ACK_STAT 8'h20
`define ATRCS_PHYS_HI 11
`define ATRCS_PHYS_LO 8
`define ATRCS_TXRSP_HI 7
`define ATRCS_TXRSP_LO 4
`define ATRCS_TXREQ_HI 3
`define ATRCS_TXREQ_LO 0
`define ATRCS_DONE_BIT 31
`define ATRCS_SEL_HI 1
`define ATRCS_SEL_LO 0
`define ATRCS_RETRY_RST 4'h0
`define ATRCS_SEL_RST 2'h0
`define ATRCS_ACK_COMPLETE 4'h1
`define ATRCS_ACK_BUSY_X 4'h4
`define ATRCS_ACK_BUSY_A 4'h5
`define ATRCS_ACK_BUSY_B 4'h6
`define ATRCS_ACK_DATA_ERR 4'hd
`define ATRCS_RESP_OKAY 2'b00
`define ATRCS_RESP_SLVERR 2'b10
`endif

// file: atrcs_pkg.sv
// Types shared by the retry and swap slice
package atrcs_pkg;
    typedef enum logic [1:0] {
        ATRCS_SEL_BUS_MANAGER_ID,
        ATRCS_SEL_BANDWIDTH_AVAIL,
        ATRCS_SEL_CHANNELS_HI,
        ATRCS_SEL_CHANNELS_LO
    } atrcs_sel_e;
    typedef logic [3:0] atrcs_ack_t;
endpackage

// file: atrcs_retry_unit.sv
// Retry sequencer for one asynchronous transmit unit
`timescale 1ns/1ps
`include "atrcs_defines.svh"
module atrcs_retry_unit
    import atrcs_pkg::*;
#(
    parameter int CNT_W = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [CNT_W-1:0] i_retry_max,
    input wire logic i_start,
    input wire logic i_ack_valid,
    input wire atrcs_ack_t i_ack_code,
    output logic o_send,
    output logic o_busy,
    output logic o_done,
    output atrcs_ack_t o_status
);
    if (CNT_W < 1 || CNT_W > 8) begin : g_cnt_w_check
        $error("CNT_W out of range");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RESEND} atrcs_ru_state_e;
    atrcs_ru_state_e state_q;
    logic [CNT_W-1:0] tries_q;
    logic [CNT_W-1:0] limit_q;
    atrcs_ack_t status_q;
    logic done_q;
    logic retryable;

    // Only busy acks and data errors earn another attempt
    assign retryable = (i_ack_code == `ATRCS_ACK_BUSY_X) || (i_ack_code == `ATRCS_ACK_BUSY_A)
        || (i_ack_code == `ATRCS_ACK_BUSY_B) || (i_ack_code == `ATRCS_ACK_DATA_ERR);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            tries_q <= '0;
            limit_q <= '0;
            status_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (i_start) begin
                        // Limit latched so a mid-packet rewrite cannot stretch it
                        limit_q <= i_retry_max;
                        tries_q <= '0;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (i_ack_valid) begin
                        if (retryable && tries_q < limit_q) begin
                            tries_q <= tries_q + 1'b1;
                            state_q <= ST_RESEND;
                        end else begin
                            status_q <= i_ack_code;
                            done_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_RESEND: state_q <= ST_WAIT;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign o_send = (state_q == ST_RESEND) || (state_q == ST_IDLE && i_start);
    assign o_busy = (state_q != ST_IDLE);
    assign o_done = done_q;
    assign o_status = status_q;
endmodule

// file: atrcs_regs.sv
// Register slice: async transmit retry limits, compare-swap operands and control
//
// Overview of operation
// - Second-limit field, bits 31 to 29, always reads zero.
// - Cycle-limit field, bits 28 to 16, always reads zero.
// - Bits 15 to 12 of the retry register read zero.
// - Writable four-bit limit on physical response retransmissions.
// - Writable four-bit limit on transmit response unit retries.
// - Writable four-bit limit on transmit DMA request unit retries.
// - Retry only on busy or data-error ack, never beyond the limit.
// - Swap operand is stored into the resource only on a compare match.
// - Compare operand is checked for equality against the selected resource.
// - Done flag sets on compare-swap finish, clears on control write.
// - Two-bit select picks bus manager, bandwidth, channels high or low.
`timescale 1ns/1ps
`include "atrcs_defines.svh"
module atrcs_regs
    import atrcs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] i_swap_data,
    input wire logic [31:0] i_compare_data,
    input wire logic i_swap_start,
    input wire logic [31:0] i_res_bus_manager_id,
    input wire logic [31:0] i_res_bandwidth_avail,
    input wire logic [31:0] i_res_channels_hi,
    input wire logic [31:0] i_res_channels_lo,
    output logic o_res_we,
    output atrcs_sel_e o_res_sel,
    output logic [31:0] o_res_wdata,
    input wire logic [2:0] i_unit_start,
    input wire logic [2:0] i_unit_ack_valid,
    input wire logic [11:0] i_unit_ack_code,
    output logic [2:0] o_unit_send,
    output logic [2:0] o_unit_busy,
    output logic o_irq
);
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_addr_w_check
        $error("ADDR_W out of range");
    end

    logic [3:0] phys_response_retry_max_q;
    logic [3:0] tx_response_retry_max_q;
    logic [3:0] tx_request_retry_max_q;
    logic [31:0] swap_data_operand_q;
    logic [31:0] compare_operand_q;
    atrcs_sel_e swap_resource_select_q;
    logic swap_complete_flag_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    logic [31:0] res_wdata_q;
    logic res_we_q;
    logic [31:0] res_cur;
    logic [2:0] unit_done;
    atrcs_ack_t unit_status [3];
    logic [3:0] irq_events;

    // Write path: address and data latch independently in either order
    logic aw_have_q;
    logic w_have_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_go;
    logic wr_hit;
    logic [31:0] aw_addr_w;
    logic [31:0] ar_addr_w;
    // Zero-extended so the decode holds for any legal ADDR_W
    assign aw_addr_w = 32'(aw_addr_q);
    assign ar_addr_w = 32'(i_araddr);

    assign o_awready = !aw_have_q && !bvalid_q;
    assign o_wready = !w_have_q && !bvalid_q;
    assign wr_go = aw_have_q && w_have_q && !bvalid_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= i_awaddr;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= i_wdata;
                w_strb_q <= i_wstrb;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_comb begin
        case (aw_addr_w[7:0])
            `ATRCS_OFF_RETRY, `ATRCS_OFF_SWAP, `ATRCS_OFF_CMP, `ATRCS_OFF_CTRL,
            `ATRCS_OFF_IRQ_STAT, `ATRCS_OFF_IRQ_MASK, `ATRCS_OFF_ACK_STAT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
        if (aw_addr_w[31:8] != '0) wr_hit = 1'b0;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= `ATRCS_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `ATRCS_RESP_OKAY : `ATRCS_RESP_SLVERR;
        end else if (bvalid_q && i_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;

    logic wr_retry;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    assign wr_retry = wr_go && wr_hit && aw_addr_w[7:0] == `ATRCS_OFF_RETRY;
    assign wr_ctrl = wr_go && wr_hit && aw_addr_w[7:0] == `ATRCS_OFF_CTRL;
    assign wr_stat = wr_go && wr_hit && aw_addr_w[7:0] == `ATRCS_OFF_IRQ_STAT;
    assign wr_mask = wr_go && wr_hit && aw_addr_w[7:0] == `ATRCS_OFF_IRQ_MASK;

    // Retry limits; upper bits of the word have no storage
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            phys_response_retry_max_q <= `ATRCS_RETRY_RST;
            tx_response_retry_max_q <= `ATRCS_RETRY_RST;
            tx_request_retry_max_q <= `ATRCS_RETRY_RST;
        end else if (wr_retry) begin
            if (w_strb_q[1]) begin
                phys_response_retry_max_q <=
                    w_data_q[`ATRCS_PHYS_HI:`ATRCS_PHYS_LO];
            end
            if (w_strb_q[0]) begin
                tx_response_retry_max_q <= w_data_q[`ATRCS_TXRSP_HI:`ATRCS_TXRSP_LO];
                tx_request_retry_max_q <= w_data_q[`ATRCS_TXREQ_HI:`ATRCS_TXREQ_LO];
            end
        end
    end

    // Control: selector write; done cleared by any write, set wins
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            swap_resource_select_q <= atrcs_sel_e'(`ATRCS_SEL_RST);
            swap_complete_flag_q <= 1'b1;
        end else begin
            if (wr_ctrl && w_strb_q[0]) begin
                swap_resource_select_q <=
                    atrcs_sel_e'(w_data_q[`ATRCS_SEL_HI:`ATRCS_SEL_LO]);
            end
            if (res_we_q) begin
                swap_complete_flag_q <= 1'b1;
            end else if (wr_ctrl) begin
                swap_complete_flag_q <= 1'b0;
            end
        end
    end

    // Operands are read-only to software; the swap engine loads them
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            swap_data_operand_q <= '0;
            compare_operand_q <= '0;
        end else if (i_swap_start) begin
            swap_data_operand_q <= i_swap_data;
            compare_operand_q <= i_compare_data;
        end
    end

    always_comb begin
        case (swap_resource_select_q)
            ATRCS_SEL_BUS_MANAGER_ID: res_cur = i_res_bus_manager_id;
            ATRCS_SEL_BANDWIDTH_AVAIL: res_cur = i_res_bandwidth_avail;
            ATRCS_SEL_CHANNELS_HI: res_cur = i_res_channels_hi;
            ATRCS_SEL_CHANNELS_LO: res_cur = i_res_channels_lo;
            default: res_cur = i_res_bus_manager_id;
        endcase
    end

    // Compare step one cycle after operands land
    logic swap_pend_q;
    logic swap_hit_q;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            swap_pend_q <= 1'b0;
            res_we_q <= 1'b0;
            res_wdata_q <= '0;
            swap_hit_q <= 1'b0;
        end else begin
            swap_pend_q <= i_swap_start;
            res_we_q <= swap_pend_q;
            if (swap_pend_q) begin
                swap_hit_q <= (res_cur == compare_operand_q);
                res_wdata_q <= swap_data_operand_q;
            end
        end
    end

    // Write strobe only on a match; done still sets on a miss
    assign o_res_we = res_we_q && swap_hit_q;
    assign o_res_wdata = res_wdata_q;
    assign o_res_sel = swap_resource_select_q;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_unit
            logic [3:0] lim;
            assign lim = (gi == 0) ? phys_response_retry_max_q :
                (gi == 1) ? tx_response_retry_max_q : tx_request_retry_max_q;
            atrcs_retry_unit #(
                .CNT_W(4)
            ) u_unit (
                .i_clk_sys(i_clk_sys),
                .i_rst(i_rst),
                .i_retry_max(lim),
                .i_start(i_unit_start[gi]),
                .i_ack_valid(i_unit_ack_valid[gi]),
                .i_ack_code(i_unit_ack_code[gi*4 +: 4]),
                .o_send(o_unit_send[gi]),
                .o_busy(o_unit_busy[gi]),
                .o_done(unit_done[gi]),
                .o_status(unit_status[gi])
            );
        end
    endgenerate

    // Events: bit 3 swap done, bits 2..0 unit completions
    assign irq_events = {res_we_q, unit_done};
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else begin
            irq_stat_q <= irq_events | (irq_stat_q & ~(wr_stat ? w_data_q[3:0] : 4'h0));
            if (wr_mask) begin
                irq_mask_q <= w_data_q[3:0];
            end
        end
    end
    assign o_irq = |(irq_stat_q & irq_mask_q);

    // Read path
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] rd_word;
    logic rd_hit;
    assign o_arready = !rvalid_q;

    always_comb begin
        rd_word = 32'h0;
        rd_hit = (ar_addr_w[31:8] == '0);
        case (ar_addr_w[7:0])
            `ATRCS_OFF_RETRY: begin
                // Dual-phase fields and bits 15..12 have no storage
                rd_word[`ATRCS_PHYS_HI:`ATRCS_PHYS_LO] = phys_response_retry_max_q;
                rd_word[`ATRCS_TXRSP_HI:`ATRCS_TXRSP_LO] = tx_response_retry_max_q;
                rd_word[`ATRCS_TXREQ_HI:`ATRCS_TXREQ_LO] = tx_request_retry_max_q;
            end
            `ATRCS_OFF_SWAP: rd_word = swap_data_operand_q;
            `ATRCS_OFF_CMP: rd_word = compare_operand_q;
            `ATRCS_OFF_CTRL: begin
                rd_word[`ATRCS_DONE_BIT] = swap_complete_flag_q;
                rd_word[`ATRCS_SEL_HI:`ATRCS_SEL_LO] = swap_resource_select_q;
            end
            `ATRCS_OFF_IRQ_STAT: rd_word[3:0] = irq_stat_q;
            `ATRCS_OFF_IRQ_MASK: rd_word[3:0] = irq_mask_q;
            `ATRCS_OFF_ACK_STAT: rd_word[11:0] = {unit_status[2], unit_status[1], unit_status[0]};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `ATRCS_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_hit ? rd_word : 32'h0;
            rresp_q <= rd_hit ? `ATRCS_RESP_OKAY : `ATRCS_RESP_SLVERR;
        end else if (rvalid_q && i_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
endmodule

// file: atrcs_regs_checker.sv
// Concurrent checks on the retry and swap register slice ports
`timescale 1ns/1ps
`include "atrcs_defines.svh"
module atrcs_regs_checker
    import atrcs_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [31:0] i_swap_data,
    input wire logic [31:0] i_compare_data,
    input wire logic i_swap_start,
    input wire logic [31:0] i_res_bus_manager_id,
    input wire logic [31:0] i_res_bandwidth_avail,
    input wire logic [31:0] i_res_channels_hi,
    input wire logic [31:0] i_res_channels_lo,
    input wire logic o_res_we,
    input wire atrcs_sel_e o_res_sel,
    input wire logic [31:0] o_res_wdata,
    input wire logic [2:0] i_unit_start,
    input wire logic [2:0] i_unit_ack_valid,
    input wire logic [11:0] i_unit_ack_code,
    input wire logic [2:0] o_unit_send,
    input wire logic [2:0] o_unit_busy
);
    logic [31:0] cur_res;
    // Resources are assumed steady across one compare-swap
    assign cur_res = (o_res_sel == ATRCS_SEL_BUS_MANAGER_ID) ? i_res_bus_manager_id :
                     (o_res_sel == ATRCS_SEL_BANDWIDTH_AVAIL) ? i_res_bandwidth_avail :
                     (o_res_sel == ATRCS_SEL_CHANNELS_HI) ? i_res_channels_hi : i_res_channels_lo;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    a_res_we_cause: assert property (o_res_we |-> $past(i_swap_start, 2))
        else $error("resource write without a compare-swap");
    a_match_write: assert property ($past(i_swap_start, 2) |->
        o_res_we == ($past(i_compare_data, 2) == cur_res))
        else $error("resource write does not follow the compare");
    a_swap_value: assert property (o_res_we |-> o_res_wdata == $past(i_swap_data, 2))
        else $error("resource written with wrong data");
    a_we_pulse: assert property (o_res_we |=> !o_res_we)
        else $error("resource write longer than one cycle");
    a_sel_stable: assert property (o_res_we |-> $stable(o_res_sel))
        else $error("select moved during resource write");
    a_retry_cause: assert property (o_unit_send[0] && !i_unit_start[0] |->
        $past(i_unit_ack_valid[0]) && ($past(i_unit_ack_code[3:0]) inside
        {`ATRCS_ACK_BUSY_X, `ATRCS_ACK_BUSY_A, `ATRCS_ACK_BUSY_B, `ATRCS_ACK_DATA_ERR}))
        else $error("retransmit without a busy or error ack");
    a_start_busy: assert property (i_unit_start[1] && !o_unit_busy[1] |=>
        o_unit_busy[1] && !o_unit_send[1])
        else $error("unit not busy after start");
    a_done_stop: assert property (o_unit_busy[2] && i_unit_ack_valid[2] &&
        i_unit_ack_code[11:8] == `ATRCS_ACK_COMPLETE |=> !o_unit_busy[2] [*2])
        else $error("unit kept going after a complete ack");
endmodule
bind atrcs_regs atrcs_regs_checker u_atrcs_regs_checker (.i_clk_sys, .i_rst, .i_swap_data,
    .i_compare_data, .i_swap_start, .i_res_bus_manager_id, .i_res_bandwidth_avail,
    .i_res_channels_hi, .i_res_channels_lo, .o_res_we, .o_res_sel, .o_res_wdata,
    .i_unit_start, .i_unit_ack_valid, .i_unit_ack_code, .o_unit_send, .o_unit_busy);

// file: atrcs_ack_node.sv
// Remote node model: acknowledges each transmitted packet after a delay
`timescale 1ns/1ps
`include "atrcs_defines.svh"
module atrcs_ack_node (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_arm,
    input wire logic [2:0] i_send,
    input wire logic [3:0] i_delay,
    input wire logic [3:0] i_busy_code,
    input wire logic [11:0] i_busy_n,
    output logic [2:0] o_ack_valid,
    output logic [11:0] o_ack_code
);
    logic [2:0] pend_q;
    logic [3:0] wait_q [3];
    logic [3:0] left_q [3];
    always_ff @(posedge i_clk_sys) begin
        for (int u = 0; u < 3; u++) begin
            o_ack_valid[u] <= 1'b0;
            // Code lines toggle between acks so a stale code never looks valid
            o_ack_code[4*u +: 4] <= ~o_ack_code[4*u +: 4];
            if (i_arm) begin
                left_q[u] <= i_busy_n[4*u +: 4];
            end
            if (i_rst) begin
                pend_q[u] <= 1'b0;
                o_ack_code[4*u +: 4] <= 4'h0;
            end else if (i_send[u]) begin
                pend_q[u] <= 1'b1;
                wait_q[u] <= i_delay;
            end else if (pend_q[u] && wait_q[u] == 4'h0) begin
                // Busy or error acks first, then a complete ack
                pend_q[u] <= 1'b0;
                o_ack_valid[u] <= 1'b1;
                o_ack_code[4*u +: 4] <= (left_q[u] != 4'h0) ? i_busy_code : `ATRCS_ACK_COMPLETE;
                if (left_q[u] != 4'h0) begin
                    left_q[u] <= left_q[u] - 4'h1;
                end
            end else if (pend_q[u]) begin
                wait_q[u] <= wait_q[u] - 4'h1;
            end
        end
    end
endmodule

// file: atrcs_regs_test.sv
// Self-checking bench for the retry and swap register slice
`timescale 1ns/1ps
module atrcs_regs_test
    import atrcs_pkg::*;
;
    logic i_clk_sys = 1'b0, i_rst = 1'b1, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, i_swap_start = 1'b0, arm = 1'b0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_res_we, o_irq;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0, i_swap_data = 32'h0, i_compare_data = 32'h0;
    logic [31:0] i_res_bus_manager_id = 32'h1357_0000, i_res_bandwidth_avail = 32'h1357_0001;
    logic [31:0] i_res_channels_hi = 32'h1357_0002, i_res_channels_lo = 32'h1357_0003;
    logic [31:0] o_rdata, o_res_wdata, rd, last_wd;
    logic [3:0] i_wstrb = 4'h0, dly = 4'h0, bcode = 4'h0;
    logic [2:0] i_unit_start = 3'h0, i_unit_ack_valid, o_unit_send, o_unit_busy;
    logic [11:0] i_unit_ack_code;
    logic [1:0] o_bresp, o_rresp, rs;
    atrcs_sel_e o_res_sel, last_sel;
    int miscompares = 0, check_count = 0, cyc = 0, we_n = 0;
    int sends [3] = '{0, 0, 0};

    atrcs_regs u_atrcs_regs (.i_clk_sys, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
        .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_swap_data, .i_compare_data,
        .i_swap_start, .i_res_bus_manager_id, .i_res_bandwidth_avail, .i_res_channels_hi,
        .i_res_channels_lo, .o_res_we, .o_res_sel, .o_res_wdata, .i_unit_start,
        .i_unit_ack_valid, .i_unit_ack_code, .o_unit_send, .o_unit_busy, .o_irq);
    atrcs_ack_node u_atrcs_ack_node (.i_clk_sys, .i_rst, .i_arm(arm), .i_send(o_unit_send),
        .i_delay(dly), .i_busy_code(bcode), .i_busy_n(12'h255),
        .o_ack_valid(i_unit_ack_valid), .o_ack_code(i_unit_ack_code));

    always #4 i_clk_sys = ~i_clk_sys;

    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (o_res_we === 1'b1) begin
            we_n <= we_n + 1;
            last_sel <= o_res_sel;
            last_wd <= o_res_wdata;
        end
        for (int u = 0; u < 3; u++) begin
            if (o_unit_send[u] === 1'b1) sends[u] <= sends[u] + 1;
        end
        // Ceiling well above the roughly 360 cycles the tests need
        if (cyc == 30000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic test_done();
        if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= s;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (o_bvalid !== 1'b1);
        rs = o_bresp;
        i_bready <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    task automatic axr(input logic [7:0] a);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            if (o_arready) i_arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1);
        rd = o_rdata;
        rs = o_rresp;
        i_rready <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        axr(a);
        chk(n, rd, e);
    endtask

    function automatic logic [31:0] res_of(input logic [1:0] s);
        return 32'h1357_0000 + {30'h0, s};
    endfunction

    task automatic swap(input logic [1:0] s, input logic hit);
        int n;
        n = we_n;
        axw(8'h14, {30'h0, s}, 4'hf);
        rc("ctrl cleared", 8'h14, {30'h0, s});
        i_swap_data <= 32'hc0de_0000 + {30'h0, s};
        i_compare_data <= hit ? res_of(s) : ~res_of(s);
        i_swap_start <= 1'b1;
        @(posedge i_clk_sys);
        i_swap_start <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        rc("ctrl done", 8'h14, {1'b1, 29'h0, s});
        rc("swap operand", 8'h0c, 32'hc0de_0000 + {30'h0, s});
        rc("compare operand", 8'h10, hit ? res_of(s) : ~res_of(s));
        chk("resource writes", we_n - n, {31'h0, hit});
        if (hit) chk("resource select", {30'h0, last_sel}, {30'h0, s});
        if (hit) chk("resource data", last_wd, 32'hc0de_0000 + {30'h0, s});
    endtask

    // Limits phys 2, response 0, request 3; node sends 5, 5, 2 busy acks
    task automatic retry(input logic [3:0] c, input logic [3:0] d);
        int b [3];
        logic ok;
        ok = c inside {4'h4, 4'h5, 4'h6, 4'hd};
        bcode <= c;
        dly <= d;
        arm <= 1'b1;
        @(posedge i_clk_sys);
        arm <= 1'b0;
        b = sends;
        i_unit_start <= 3'b111;
        @(posedge i_clk_sys);
        i_unit_start <= 3'b000;
        repeat (2) @(posedge i_clk_sys);
        while (o_unit_busy !== 3'b000) @(posedge i_clk_sys);
        repeat (2) @(posedge i_clk_sys);
        chk("phys sends", sends[0] - b[0], ok ? 32'h3 : 32'h1);
        chk("response sends", sends[1] - b[1], 32'h1);
        chk("request sends", sends[2] - b[2], ok ? 32'h3 : 32'h1);
        rc("ack status", 8'h20, {20'h0, ok ? 4'h1 : c, c, c});
        chk("irq on done", {31'h0, o_irq}, 32'h1);
        axw(8'h18, 32'h7, 4'hf);
        rc("status cleared", 8'h18, 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rc("retry reset", 8'h08, 32'h0);
        rc("ctrl reset", 8'h14, 32'h8000_0000);
        axw(8'h08, 32'hffff_ffff, 4'hf);
        rc("retry ones", 8'h08, 32'h0000_0fff);
        axw(8'h08, 32'h0000_0321, 4'h1);
        rc("retry low lane", 8'h08, 32'h0000_0f21);
        axw(8'h08, 32'h0000_0203, 4'h3);
        rc("retry limits", 8'h08, 32'h0000_0203);
        axr(8'h40);
        chk("unmapped read", {rs, rd[29:0]}, 32'h8000_0000);
        axw(8'h44, 32'h1, 4'hf);
        chk("unmapped write", {30'h0, rs}, 32'h2);
        axw(8'h1c, 32'hf, 4'hf);
        for (int s = 0; s < 8; s++) swap(s[1:0], s[2]);
        axw(8'h0c, 32'h0, 4'hf);
        rc("swap read only", 8'h0c, 32'hc0de_0003);
        chk("irq on swap", {31'h0, o_irq}, 32'h1);
        axw(8'h18, 32'h8, 4'hf);
        chk("irq cleared", {31'h0, o_irq}, 32'h0);
        for (int k = 0; k < 5; k++) retry(k < 4 ? 4'h4 + k[3:0] : 4'hd, {2'h0, k[0], k[0]});
        test_done();
    end
endmodule
